// ---- design/iep_arbiter.sv ----
// Combinational priority decoder: picks one request by level, then by order.
// Assumes gated requests and a service state from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "iep_params.svh"

module iep_arbiter (
  input wire iep_pkg::iep_src_vec_t i_req,
  input wire iep_pkg::iep_src_vec_t i_level,
  input wire iep_pkg::iep_svc_t i_svc,
  output logic o_valid,
  output logic [3:0] o_vec,
  output logic o_high
);

  // Lowest order number wins among requests of one level.
  function automatic logic [3:0] iep_lowest(input iep_pkg::iep_src_vec_t v);
    iep_lowest = 4'h0;
    for (int i = `IEP_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        iep_lowest = 4'(i);
      end
    end
  endfunction

  wire iep_pkg::iep_src_vec_t hi_req = i_req & i_level;
  wire iep_pkg::iep_src_vec_t lo_req = i_req & ~i_level;
  wire any_hi = |hi_req;
  wire any_lo = |lo_req;
  // A high routine in service blocks everything; a low one only blocks lows.
  wire allow_hi = (i_svc == iep_pkg::IEP_SVC_NONE) || (i_svc == iep_pkg::IEP_SVC_LOW);
  wire allow_lo = (i_svc == iep_pkg::IEP_SVC_NONE);

  assign o_valid = (any_hi && allow_hi) || (any_lo && allow_lo);
  assign o_high = any_hi;
  assign o_vec = any_hi ? iep_lowest(hi_req) : iep_lowest(lo_req);

endmodule

`default_nettype wire

// ---- design/iep_ctrl.sv ----
// Interrupt enable and priority registers with request presentation to the core.
// Assumes pending flags come from peripherals clocked by i_clk_sys, and that the
// core pulses i_irq_ack when it vectors and i_irq_reti when a routine returns.
`timescale 1ns/1ps
`default_nettype none
`include "iep_params.svh"

// Summary of operation
// - Global gate low blocks every source.
// - Serial peripheral mask gates its requests.
// - Timer two mask gates both overflows.
// - Async serial mask gates its request.
// - Timer one mask gates its overflow.
// - External input one mask gates requests.
// - Timer zero mask gates its overflow.
// - External input zero mask gates requests.
// - Base priority top bit reads one always.
// - Base priority bits choose low or high.
// - Timer three mask gates both overflows.
// - Comparator one mask gates edge flags.
// - Comparator zero mask gates edge flags.
// - Counter array mask gates all requests.
// - Conversion done mask gates its request.
// - Window compare mask gates its flag.
// - Management serial mask gates all requests.
// - Extended reserved bit one reads zero.
// - Extended priority bits choose low or high.
// - High preempts low; high never preempted.
// - Equal level resolved by fixed order.
// - Requests decoded every cycle, one detect.
module iep_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_ext_input_zero,
  input wire logic i_timer_zero_overflow,
  input wire logic i_ext_input_one,
  input wire logic i_timer_one_overflow,
  input wire logic i_async_serial_pend,
  input wire logic i_timer_two_low_overflow,
  input wire logic i_timer_two_high_overflow,
  input wire logic i_serial_periph_pend,
  input wire logic i_mgmt_serial_pend,
  input wire logic i_window_compare_flag,
  input wire logic i_conversion_done_pend,
  input wire logic i_counter_array_pend,
  input wire logic i_comparator_zero_rise_flag,
  input wire logic i_comparator_zero_fall_flag,
  input wire logic i_comparator_one_rise_flag,
  input wire logic i_comparator_one_fall_flag,
  input wire logic i_timer_three_low_overflow,
  input wire logic i_timer_three_high_overflow,
  input wire logic i_irq_ack,
  input wire logic i_irq_reti,
  output logic o_irq_req,
  output logic [3:0] o_irq_vec,
  output logic o_irq_high,
  output iep_pkg::iep_svc_t o_svc_state
);

  function automatic logic iep_hit(input logic [7:0] addr, input logic [7:0] offset);
    iep_hit = (addr == offset);
  endfunction

  logic [7:0] interrupt_enable_base;
  logic [7:0] interrupt_priority_base;
  logic [7:0] interrupt_enable_extended;
  logic [7:0] interrupt_priority_extended;
  iep_pkg::iep_svc_t next_svc;
  logic arb_valid;
  logic [3:0] arb_vec;
  logic arb_high;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Register decode.
  wire sel_en_base = iep_hit(i_sfr_addr, `IEP_ADDR_EN_BASE);
  wire sel_pri_base = iep_hit(i_sfr_addr, `IEP_ADDR_PRI_BASE);
  wire sel_en_ext = iep_hit(i_sfr_addr, `IEP_ADDR_EN_EXT);
  wire sel_pri_ext = iep_hit(i_sfr_addr, `IEP_ADDR_PRI_EXT);
  wire sel_any = sel_en_base | sel_pri_base | sel_en_ext | sel_pri_ext;

  wire wr_en_base = i_sfr_wr && sel_en_base;
  wire wr_pri_base = i_sfr_wr && sel_pri_base;
  wire wr_en_ext = i_sfr_wr && sel_en_ext;
  wire wr_pri_ext = i_sfr_wr && sel_pri_ext;

  // The unused top bit of base priority is forced so it can never be cleared.
  wire [7:0] next_pri_base = i_sfr_wdata | `IEP_PRI_BASE_ONES;
  // Reserved bit one is never stored, so a careless write cannot set it.
  wire [7:0] next_en_ext = i_sfr_wdata & `IEP_EXT_WMASK;
  wire [7:0] next_pri_ext = i_sfr_wdata & `IEP_EXT_WMASK;

  wire [7:0] read_value = sel_en_base ? interrupt_enable_base :
                          sel_pri_base ? interrupt_priority_base :
                          sel_en_ext ? interrupt_enable_extended :
                          sel_pri_ext ? interrupt_priority_extended : 8'h00;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      interrupt_enable_base <= `IEP_RST_EN_BASE;
      interrupt_priority_base <= `IEP_RST_PRI_BASE;
      interrupt_enable_extended <= `IEP_RST_EN_EXT;
      interrupt_priority_extended <= `IEP_RST_PRI_EXT;
    end else if (i_ce) begin
      if (wr_en_base) begin
        interrupt_enable_base <= i_sfr_wdata;
      end
      if (wr_pri_base) begin
        interrupt_priority_base <= next_pri_base;
      end
      if (wr_en_ext) begin
        interrupt_enable_extended <= next_en_ext;
      end
      if (wr_pri_ext) begin
        interrupt_priority_extended <= next_pri_ext;
      end
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero with no hit.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
    end else if (i_ce) begin
      o_sfr_rdata <= i_sfr_rd ? read_value : 8'h00;
      o_sfr_hit <= i_sfr_rd && sel_any;
    end
  end

  // Named register fields.
  wire global_irq_gate = interrupt_enable_base[`IEP_BIT_GLOBAL];
  wire serial_periph_irq_mask = interrupt_enable_base[`IEP_BIT_SPI];
  wire timer_two_irq_mask = interrupt_enable_base[`IEP_BIT_TMR2];
  wire async_serial_irq_mask = interrupt_enable_base[`IEP_BIT_UART];
  wire timer_one_irq_mask = interrupt_enable_base[`IEP_BIT_TMR1];
  wire ext_input_one_irq_mask = interrupt_enable_base[`IEP_BIT_EXT1];
  wire timer_zero_irq_mask = interrupt_enable_base[`IEP_BIT_TMR0];
  wire ext_input_zero_irq_mask = interrupt_enable_base[`IEP_BIT_EXT0];
  wire timer_three_irq_mask = interrupt_enable_extended[`IEP_BIT_TMR3];
  wire comparator_one_irq_mask = interrupt_enable_extended[`IEP_BIT_CMP1];
  wire comparator_zero_irq_mask = interrupt_enable_extended[`IEP_BIT_CMP0];
  wire counter_array_irq_mask = interrupt_enable_extended[`IEP_BIT_PCA];
  wire conversion_done_irq_mask = interrupt_enable_extended[`IEP_BIT_CONV];
  wire window_compare_irq_mask = interrupt_enable_extended[`IEP_BIT_WIN];
  wire mgmt_serial_irq_mask = interrupt_enable_extended[`IEP_BIT_SMB];
  wire timer_three_irq_level = interrupt_priority_extended[`IEP_BIT_TMR3];

  // Sources in fixed order; slot eight has no source.
  wire iep_pkg::iep_src_vec_t pend_vec = {
    i_timer_three_low_overflow | i_timer_three_high_overflow,
    i_comparator_one_rise_flag | i_comparator_one_fall_flag,
    i_comparator_zero_rise_flag | i_comparator_zero_fall_flag,
    i_counter_array_pend,
    i_conversion_done_pend,
    i_window_compare_flag,
    1'b0,
    i_mgmt_serial_pend,
    i_serial_periph_pend,
    i_timer_two_low_overflow | i_timer_two_high_overflow,
    i_async_serial_pend,
    i_timer_one_overflow,
    i_ext_input_one,
    i_timer_zero_overflow,
    i_ext_input_zero
  };

  wire iep_pkg::iep_src_vec_t mask_vec = {
    timer_three_irq_mask, comparator_one_irq_mask, comparator_zero_irq_mask,
    counter_array_irq_mask, conversion_done_irq_mask, window_compare_irq_mask,
    1'b0, mgmt_serial_irq_mask,
    serial_periph_irq_mask, timer_two_irq_mask, async_serial_irq_mask,
    timer_one_irq_mask, ext_input_one_irq_mask,
    timer_zero_irq_mask, ext_input_zero_irq_mask
  };

  wire iep_pkg::iep_src_vec_t level_vec = {
    interrupt_priority_extended[7:2], 1'b0, interrupt_priority_extended[0],
    interrupt_priority_base[6:0]
  };

  // Flag, own mask and global gate must all be set for a request to exist.
  wire iep_pkg::iep_src_vec_t gated = pend_vec & mask_vec & {`IEP_NUM_SRC{global_irq_gate}};

  iep_arbiter u_arbiter (
    .i_req(gated),
    .i_level(level_vec),
    .i_svc(o_svc_state),
    .o_valid(arb_valid),
    .o_vec(arb_vec),
    .o_high(arb_high)
  );

  // An acknowledged request is held off for a cycle so the core's flag clear
  // can land before the same source is offered again.
  wire next_req = arb_valid && !i_irq_ack;

  always_comb begin
    next_svc = o_svc_state;
    case (o_svc_state)
      iep_pkg::IEP_SVC_NONE: begin
        if (i_irq_ack) begin
          next_svc = o_irq_high ? iep_pkg::IEP_SVC_HIGH : iep_pkg::IEP_SVC_LOW;
        end
      end
      iep_pkg::IEP_SVC_LOW: begin
        if (i_irq_ack && o_irq_high) begin
          next_svc = iep_pkg::IEP_SVC_NEST;
        end else if (i_irq_reti) begin
          next_svc = iep_pkg::IEP_SVC_NONE;
        end
      end
      iep_pkg::IEP_SVC_HIGH: begin
        if (i_irq_reti) begin
          next_svc = iep_pkg::IEP_SVC_NONE;
        end
      end
      iep_pkg::IEP_SVC_NEST: begin
        if (i_irq_reti) begin
          next_svc = iep_pkg::IEP_SVC_LOW;
        end
      end
      default: begin
        next_svc = iep_pkg::IEP_SVC_NONE;
      end
    endcase
  end

  // Sampled and decoded every enabled cycle: one detect cycle to the core.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_irq_req <= 1'b0;
      o_irq_vec <= 4'h0;
      o_irq_high <= 1'b0;
      o_svc_state <= iep_pkg::IEP_SVC_NONE;
    end else if (i_ce) begin
      o_irq_req <= next_req;
      o_irq_vec <= arb_vec;
      o_irq_high <= arb_high;
      o_svc_state <= next_svc;
    end
  end

  property p_src_blocked(logic m, logic [3:0] v);
    i_ce && !m |=> !(o_irq_req && o_irq_vec == v);
  endproperty

  sequence s_low_running;
    i_ce && !i_irq_reti && o_svc_state == iep_pkg::IEP_SVC_LOW && !(i_irq_ack && o_irq_high);
  endsequence

  sequence s_high_waiting;
    i_ce && !i_irq_ack && !i_irq_reti && |(gated & level_vec);
  endsequence

  sequence s_idle_pending;
    i_ce && !i_irq_ack && o_svc_state == iep_pkg::IEP_SVC_NONE && |gated;
  endsequence

  a_global_gate_off: assert property (i_ce && !global_irq_gate |=> !o_irq_req)
    else $error("Request reached the core with the global gate low.");
  a_spi_mask: assert property (p_src_blocked(serial_periph_irq_mask, `IEP_SRC_SPI))
    else $error("Masked serial peripheral request reached the core.");
  a_timer_two_mask: assert property (p_src_blocked(timer_two_irq_mask, `IEP_SRC_TMR2))
    else $error("Masked timer two request reached the core.");
  a_async_serial_mask: assert property (p_src_blocked(async_serial_irq_mask, `IEP_SRC_UART))
    else $error("Masked async serial request reached the core.");
  a_timer_one_mask: assert property (p_src_blocked(timer_one_irq_mask, `IEP_SRC_TMR1))
    else $error("Masked timer one request reached the core.");
  a_ext_one_mask: assert property (p_src_blocked(ext_input_one_irq_mask, `IEP_SRC_EXT1))
    else $error("Masked external input one request reached the core.");
  a_timer_zero_mask: assert property (p_src_blocked(timer_zero_irq_mask, `IEP_SRC_TMR0))
    else $error("Masked timer zero request reached the core.");
  a_ext_zero_mask: assert property (p_src_blocked(ext_input_zero_irq_mask, `IEP_SRC_EXT0))
    else $error("Masked external input zero request reached the core.");
  a_timer_three_mask: assert property (p_src_blocked(timer_three_irq_mask, `IEP_SRC_TMR3))
    else $error("Masked timer three request reached the core.");
  a_comp_one_mask: assert property (p_src_blocked(comparator_one_irq_mask, `IEP_SRC_CMP1))
    else $error("Masked comparator one request reached the core.");
  a_comp_zero_mask: assert property (p_src_blocked(comparator_zero_irq_mask, `IEP_SRC_CMP0))
    else $error("Masked comparator zero request reached the core.");
  a_counter_array_mask: assert property (p_src_blocked(counter_array_irq_mask, `IEP_SRC_PCA))
    else $error("Masked counter array request reached the core.");
  a_conv_done_mask: assert property (p_src_blocked(conversion_done_irq_mask, `IEP_SRC_CONV))
    else $error("Masked conversion done request reached the core.");
  a_window_mask: assert property (p_src_blocked(window_compare_irq_mask, `IEP_SRC_WIN))
    else $error("Masked window compare request reached the core.");
  a_mgmt_serial_mask: assert property (p_src_blocked(mgmt_serial_irq_mask, `IEP_SRC_SMB))
    else $error("Masked management serial request reached the core.");
  a_pri_top_one: assert property (i_ce && i_sfr_rd && sel_pri_base |=> o_sfr_hit && o_sfr_rdata[7])
    else $error("Base priority top bit did not read as one.");
  a_reserved_zero: assert property (i_ce && i_sfr_rd && (sel_en_ext || sel_pri_ext)
      |=> o_sfr_hit && !o_sfr_rdata[`IEP_BIT_RSVD])
    else $error("Extended reserved bit did not read as zero.");
  a_high_first: assert property (s_idle_pending and (i_ce && |(gated & level_vec))
      |=> o_irq_req && o_irq_high)
    else $error("High level request lost to a low one.");
  a_timer_three_level: assert property (s_idle_pending and (i_ce && gated[14] && timer_three_irq_level)
      |=> o_irq_high)
    else $error("Timer three high level not presented as high.");
  a_high_unpreempted: assert property (i_ce && o_svc_state inside {iep_pkg::IEP_SVC_HIGH, iep_pkg::IEP_SVC_NEST}
      |=> !o_irq_req)
    else $error("Request offered while a high routine runs.");
  a_low_preempted: assert property (s_low_running ##1 s_high_waiting |=> o_irq_req && o_irq_high)
    else $error("High request did not preempt a low routine.");
  a_fixed_order: assert property (s_idle_pending and (i_ce && gated[0] && ~|(gated & level_vec))
      |=> o_irq_vec == `IEP_SRC_EXT0)
    else $error("Lowest order source was not chosen.");
  a_one_detect: assert property (s_idle_pending |=> o_irq_req)
    else $error("Pending enabled request not presented after one cycle.");
  a_withdrawn: assert property (i_ce && ~|gated |=> !o_irq_req)
    else $error("Request held after flag, mask or gate cleared.");

endmodule

`default_nettype wire

// ---- include/iep_params.svh ----
// Constants of the interrupt enable and priority block: register offsets,
// reset values, field positions and source order numbers.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IEP_PARAMS_SVH
`define IEP_PARAMS_SVH

`define IEP_ADDR_EN_BASE 8'hA8
`define IEP_ADDR_PRI_BASE 8'hB8
`define IEP_ADDR_EN_EXT 8'hE6
`define IEP_ADDR_PRI_EXT 8'hF6

`define IEP_RST_EN_BASE 8'h00
`define IEP_RST_PRI_BASE 8'h80
`define IEP_RST_EN_EXT 8'h00
`define IEP_RST_PRI_EXT 8'h00

`define IEP_PRI_BASE_ONES 8'h80
`define IEP_EXT_WMASK 8'hFD

`define IEP_BIT_GLOBAL 7
`define IEP_BIT_SPI 6
`define IEP_BIT_TMR2 5
`define IEP_BIT_UART 4
`define IEP_BIT_TMR1 3
`define IEP_BIT_EXT1 2
`define IEP_BIT_TMR0 1
`define IEP_BIT_EXT0 0
`define IEP_BIT_TMR3 7
`define IEP_BIT_CMP1 6
`define IEP_BIT_CMP0 5
`define IEP_BIT_PCA 4
`define IEP_BIT_CONV 3
`define IEP_BIT_WIN 2
`define IEP_BIT_RSVD 1
`define IEP_BIT_SMB 0

`define IEP_NUM_SRC 15
`define IEP_SRC_EXT0 4'h0
`define IEP_SRC_TMR0 4'h1
`define IEP_SRC_EXT1 4'h2
`define IEP_SRC_TMR1 4'h3
`define IEP_SRC_UART 4'h4
`define IEP_SRC_TMR2 4'h5
`define IEP_SRC_SPI 4'h6
`define IEP_SRC_SMB 4'h7
`define IEP_SRC_WIN 4'h9
`define IEP_SRC_CONV 4'hA
`define IEP_SRC_PCA 4'hB
`define IEP_SRC_CMP0 4'hC
`define IEP_SRC_CMP1 4'hD
`define IEP_SRC_TMR3 4'hE

`endif

// ---- include/iep_pkg.sv ----
// Types shared by the interrupt enable and priority block.
// Assumes iep_params.svh is on the include path.
`include "iep_params.svh"

package iep_pkg;

  typedef logic [`IEP_NUM_SRC-1:0] iep_src_vec_t;

  typedef enum logic [1:0] {
    IEP_SVC_NONE = 2'b00,
    IEP_SVC_LOW = 2'b01,
    IEP_SVC_HIGH = 2'b10,
    IEP_SVC_NEST = 2'b11
  } iep_svc_t;

endpackage

// ---- tb/iep_core_model.sv ----
// Behavioural model of the processor core side of the interrupt request path.
// Assumes the bench calls take and leave from a falling edge of i_clk_sys.
`timescale 1ns/1ps
`default_nettype none

module iep_core_model (
  input wire logic i_clk_sys,
  input wire logic i_irq_req,
  input wire logic [3:0] i_irq_vec,
  input wire logic i_irq_high,
  output logic o_irq_ack,
  output logic o_irq_reti
);
  initial begin
    o_irq_ack = 1'b0;
    o_irq_reti = 1'b0;
  end

  // The core vectors only to a request that is presented, with a one-cycle pulse.
  // It never acknowledges blindly, so a missing request shows up as a state mismatch.
  task automatic take(output logic [3:0] vec, output logic high);
    vec = i_irq_vec;
    high = i_irq_high;
    o_irq_ack = i_irq_req;
    @(negedge i_clk_sys);
    o_irq_ack = 1'b0;
    @(negedge i_clk_sys);
  endtask

  task automatic leave();
    o_irq_reti = 1'b1;
    @(negedge i_clk_sys);
    o_irq_reti = 1'b0;
    @(negedge i_clk_sys);
  endtask
endmodule

`default_nettype wire

// ---- tb/interrupt_enable_priority_regs_bench.sv ----
// Self-checking bench of the interrupt enable and priority registers.
// Assumes iep_params.svh on the include path and the core model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "iep_params.svh"

module interrupt_enable_priority_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [17:0] fl = 18'h00000;
  logic [7:0] rdata;
  logic hit;
  logic req;
  logic [3:0] vec;
  logic high;
  logic ack;
  logic reti;
  iep_pkg::iep_svc_t state;
  int errors = 0;
  int compares = 0;
  // Order number of each pending-flag input, in port order.
  localparam logic [3:0] SRC [18] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7,
    4'h9, 4'hA, 4'hB, 4'hC, 4'hC, 4'hD, 4'hD, 4'hE, 4'hE};

  always #12.5 clk = ~clk;

  iep_ctrl dut (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(sfr_wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(sfr_rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .i_ext_input_zero(fl[0]), .i_timer_zero_overflow(fl[1]), .i_ext_input_one(fl[2]),
    .i_timer_one_overflow(fl[3]), .i_async_serial_pend(fl[4]), .i_timer_two_low_overflow(fl[5]),
    .i_timer_two_high_overflow(fl[6]), .i_serial_periph_pend(fl[7]), .i_mgmt_serial_pend(fl[8]),
    .i_window_compare_flag(fl[9]), .i_conversion_done_pend(fl[10]), .i_counter_array_pend(fl[11]),
    .i_comparator_zero_rise_flag(fl[12]), .i_comparator_zero_fall_flag(fl[13]),
    .i_comparator_one_rise_flag(fl[14]), .i_comparator_one_fall_flag(fl[15]),
    .i_timer_three_low_overflow(fl[16]), .i_timer_three_high_overflow(fl[17]),
    .i_irq_ack(ack), .i_irq_reti(reti), .o_irq_req(req), .o_irq_vec(vec), .o_irq_high(high),
    .o_svc_state(state)
  );

  iep_core_model core (
    .i_clk_sys(clk), .i_irq_req(req), .i_irq_vec(vec), .i_irq_high(high),
    .o_irq_ack(ack), .o_irq_reti(reti)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Each access spends a second cycle idle so a strobe is never lowered and raised in one step.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(rdata, exp, "read data");
    chk({7'h00, hit}, {7'h00, exp_hit}, "read hit");
    @(negedge clk);
  endtask

  // One registered edge before the request shows, plus one spare edge.
  task automatic see(input logic r, input logic [3:0] v, input logic h, input iep_pkg::iep_svc_t s);
    repeat (2) @(negedge clk);
    chk({7'h00, req}, {7'h00, r}, "request");
    if (r) begin
      chk({4'h0, vec}, {4'h0, v}, "vector");
      chk({7'h00, high}, {7'h00, h}, "level");
    end
    chk({6'h00, state}, {6'h00, s}, "service state");
  endtask

  task automatic t_regs();
    bus_rd(`IEP_ADDR_EN_BASE, `IEP_RST_EN_BASE, 1'b1);
    bus_rd(`IEP_ADDR_PRI_BASE, `IEP_RST_PRI_BASE, 1'b1);
    bus_rd(`IEP_ADDR_EN_EXT, `IEP_RST_EN_EXT, 1'b1);
    bus_rd(`IEP_ADDR_PRI_EXT, `IEP_RST_PRI_EXT, 1'b1);
    bus_rd(8'h00, 8'h00, 1'b0);
    bus_wr(`IEP_ADDR_EN_BASE, 8'hFF);
    bus_wr(`IEP_ADDR_PRI_BASE, 8'h7F);
    bus_wr(`IEP_ADDR_EN_EXT, 8'hFF);
    bus_wr(`IEP_ADDR_PRI_EXT, 8'hFF);
    bus_wr(8'hA9, 8'h00);
    bus_rd(`IEP_ADDR_EN_BASE, 8'hFF, 1'b1);
    bus_rd(`IEP_ADDR_PRI_BASE, 8'hFF, 1'b1);
    bus_rd(`IEP_ADDR_EN_EXT, 8'hFD, 1'b1);
    bus_rd(`IEP_ADDR_PRI_EXT, 8'hFD, 1'b1);
    bus_wr(`IEP_ADDR_PRI_BASE, 8'h00);
    bus_rd(`IEP_ADDR_PRI_BASE, 8'h80, 1'b1);
    ce = 1'b0;
    bus_wr(`IEP_ADDR_EN_BASE, 8'h00);
    ce = 1'b1;
    bus_rd(`IEP_ADDR_EN_BASE, 8'hFF, 1'b1);
    bus_wr(`IEP_ADDR_EN_BASE, 8'h00);
    bus_wr(`IEP_ADDR_EN_EXT, 8'h00);
    bus_wr(`IEP_ADDR_PRI_EXT, 8'h00);
  endtask

  task automatic t_masks();
    logic [15:0] m;
    for (int i = 0; i < 18; i++) begin
      m = 16'h0001 << ((SRC[i] < 4'h7) ? SRC[i] : SRC[i] + 4'h1);
      fl = 18'h00000;
      fl[i] = 1'b1;
      bus_wr(`IEP_ADDR_EN_EXT, m[15:8]);
      bus_wr(`IEP_ADDR_EN_BASE, m[7:0]);
      see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_NONE);
      bus_wr(`IEP_ADDR_EN_BASE, 8'h80 | m[7:0]);
      see(1'b1, SRC[i], 1'b0, iep_pkg::IEP_SVC_NONE);
      bus_wr(`IEP_ADDR_EN_EXT, 8'h00);
      bus_wr(`IEP_ADDR_EN_BASE, 8'h80);
      see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_NONE);
    end
    fl = 18'h00000;
  endtask

  task automatic t_priority();
    logic [3:0] v;
    logic h;
    bus_wr(`IEP_ADDR_EN_BASE, 8'hFF);
    bus_wr(`IEP_ADDR_EN_EXT, 8'hFD);
    fl = 18'h2000C;
    see(1'b1, 4'h2, 1'b0, iep_pkg::IEP_SVC_NONE);
    bus_wr(`IEP_ADDR_PRI_EXT, 8'h80);
    see(1'b1, 4'hE, 1'b1, iep_pkg::IEP_SVC_NONE);
    core.take(v, h);
    chk({4'h0, v}, {4'h0, `IEP_SRC_TMR3}, "taken vector");
    chk({7'h00, h}, {7'h00, 1'b1}, "taken level");
    see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_HIGH);
    fl[17] = 1'b0;
    core.leave();
    bus_wr(`IEP_ADDR_PRI_EXT, 8'h00);
    bus_wr(`IEP_ADDR_PRI_BASE, 8'h01);
    see(1'b1, 4'h2, 1'b0, iep_pkg::IEP_SVC_NONE);
    core.take(v, h);
    chk({4'h0, v}, {4'h0, `IEP_SRC_EXT1}, "taken vector");
    chk({7'h00, h}, {7'h00, 1'b0}, "taken level");
    fl[2] = 1'b0;
    see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_LOW);
    fl[0] = 1'b1;
    see(1'b1, 4'h0, 1'b1, iep_pkg::IEP_SVC_LOW);
    core.take(v, h);
    chk({4'h0, v}, {4'h0, `IEP_SRC_EXT0}, "taken vector");
    chk({7'h00, h}, {7'h00, 1'b1}, "taken level");
    fl[0] = 1'b0;
    see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_NEST);
    core.leave();
    see(1'b0, 4'h0, 1'b0, iep_pkg::IEP_SVC_LOW);
    core.leave();
    see(1'b1, 4'h3, 1'b0, iep_pkg::IEP_SVC_NONE);
    fl = 18'h00000;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_masks();
    t_priority();
    print_verdict();
  end

  // The tests need under 1500 cycles; the limit leaves wide margin.
  initial begin
    #(25 * 5000);
    errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
